// ### bmsc_params.svh
`ifndef BMSC_PARAMS_SVH
`define BMSC_PARAMS_SVH
// Notes on behaviour
// - An enabled source with its raw flag high sets its latched alarm bit.
// - Switch state bit 6 reads one while the alert output is asserted.
// - Switch state bits 3..0 show predischarge, discharge, precharge, charge.
// - 0x000F twice in a row within 4 s enters deep rest; 0x000E leaves it.
// - 0x0010 starts shutdown; locked it needs two in 4 s, two unlocked skip delays.
// - 0x0030 locks; locked, reset, switch tests, mfg toggles and config entry are ignored.
// - In test mode 0x001C/1E/1F/20 toggle predischarge, precharge, charge, discharge.
// - 0x0022 toggles firmware switch control, where zero means switch test mode.
// - 0x0024 toggles the permanent fault check enable.
// - 0x0082 clears accumulated charge and its timer, restarting charge at half a unit.
// - 0x008A triggers precharge timeout recovery and restarts any running precharge timer.
// - 0x0090 enters config edit if unlocked; 0x0092 leaves, clears power-on, watchdog.
// - 0x0093 blocks discharge drivers, 0x0094 charge drivers, 0x0095 all four drivers.
// - 0x0096 clears every driver block left by the three driver-off codes.
// - Sleep allowed loads a default, then 0x0099 allows and 0x009A forbids sleep.

// ------------------------------------------------------------
// Command codes
// ------------------------------------------------------------
`define BMSC_LEAVE_DEEP_REST      16'h000e
`define BMSC_ENTER_DEEP_REST      16'h000f
`define BMSC_SHUTDOWN             16'h0010
`define BMSC_DEVICE_RESET         16'h0012
`define BMSC_PREDISCHARGE_TEST    16'h001c
`define BMSC_PRECHARGE_TEST       16'h001e
`define BMSC_CHARGE_TEST          16'h001f
`define BMSC_DISCHARGE_TEST       16'h0020
`define BMSC_SWITCH_CTRL_TOGGLE   16'h0022
`define BMSC_PERMFAULT_TOGGLE     16'h0024
`define BMSC_LOCK_ACCESS          16'h0030
`define BMSC_CLEAR_CHARGE         16'h0082
`define BMSC_PRECHARGE_RECOVERY   16'h008a
`define BMSC_ENTER_CONFIG         16'h0090
`define BMSC_LEAVE_CONFIG         16'h0092
`define BMSC_DISCHARGE_OFF        16'h0093
`define BMSC_CHARGE_OFF           16'h0094
`define BMSC_EVERY_OFF            16'h0095
`define BMSC_RELEASE_BLOCKS       16'h0096
`define BMSC_SLEEP_ALLOW          16'h0099
`define BMSC_SLEEP_FORBID         16'h009a

// ------------------------------------------------------------
// Register fields and timing
// ------------------------------------------------------------
`define BMSC_ALERT_BIT            6
`define BMSC_PAIR_WINDOW_MS       4000
`define BMSC_CLK_KHZ              25000
`define BMSC_PAIR_WINDOW_CYC      (`BMSC_PAIR_WINDOW_MS * `BMSC_CLK_KHZ)
// Half of one user charge unit in the accumulator's fixed point
`define BMSC_CHARGE_HALF          32'h0000_8000
`endif

// ### bmsc_pkg.sv
package bmsc_pkg;
    // Switch order matches the status register bits 3..0
    typedef struct packed {
        logic predischarge;
        logic discharge;
        logic precharge;
        logic charge;
    } bmsc_switch_t;

    // One-cycle pulses toward the rest of the monitor
    typedef struct packed {
        logic enter_deep_rest;
        logic leave_deep_rest;
        logic shutdown_start;
        logic shutdown_fast;
        logic device_reset;
        logic clear_accumulated_charge;
        logic precharge_timeout_recovery;
        logic clear_boot_flags;
    } bmsc_pulse_t;

    typedef enum logic [1:0] {
        BMSC_PAIR_NONE,
        BMSC_PAIR_DEEP,
        BMSC_PAIR_SHUT
    } bmsc_pair_t;
endpackage

// ### bmsc_pair_timer.sv
`timescale 1ns/1ns
// Counts down the window in which the second half of a pair must arrive
module bmsc_pair_timer #(
    parameter int WINDOW_CYC = 100000000
) (
    input  wire logic I_CLK_SYS,  // System clock
    input  wire logic I_SYS_RST,  // Sync reset
    input  wire logic i_ce,       // Clock enable
    input  wire logic i_start,    // Open the window
    input  wire logic i_stop,     // Close the window
    output logic      o_open      // Window still running
);
    localparam int CW = $clog2(WINDOW_CYC + 1);
    logic [CW-1:0] cnt_r;

    initial begin
        if (WINDOW_CYC < 1) $error("WINDOW_CYC must be positive");
    end

    always_ff @(posedge I_CLK_SYS) begin
        if (I_SYS_RST) begin
            cnt_r <= '0;
        end else if (i_ce) begin
            if (i_start) begin
                cnt_r <= CW'(WINDOW_CYC);
            end else if (i_stop) begin
                cnt_r <= '0;
            end else if (cnt_r != '0) begin
                cnt_r <= cnt_r - CW'(1);
            end
        end
    end

    assign o_open = (cnt_r != '0);
endmodule

// ### bmsc_core.sv
`timescale 1ns/1ns
`include "bmsc_params.svh"
// Subcommand decoder, alarm latch and switch status
module bmsc_core #(
    parameter int PAIR_WINDOW_CYC = `BMSC_PAIR_WINDOW_CYC
) (
    input  wire logic                  I_CLK_SYS,          // System clock
    input  wire logic                  I_SYS_RST,          // Sync reset, high
    input  wire logic                  I_CE,               // Clock enable
    input  wire logic                  I_CMD_VALID,        // Subcommand strobe
    input  wire logic [15:0]           I_CMD_CODE,         // Subcommand code
    input  wire logic                  I_OTHER_WRITE,      // Any other host write
    input  wire logic [15:0]           I_ALARM_RAW,        // Unlatched alarm flags
    input  wire logic [15:0]           I_ALARM_CLR,        // Host clear, one per bit
    input  wire logic                  I_MASK_WE,          // Mask write strobe
    input  wire logic [15:0]           I_MASK_WDATA,       // Mask write data
    input  wire logic [15:0]           I_MASK_DEFAULT,     // Mask default from memory
    input  wire logic                  I_SLEEP_DEFAULT,    // Sleep default from memory
    input  wire logic                  I_DEFAULTS_LOAD,    // Load both defaults
    input  wire logic                  I_ALERT_PIN,        // Alert pin level (async)
    input  wire bmsc_pkg::bmsc_switch_t I_SWITCH_ON,       // Switch states (async)
    output logic [15:0]                O_ALARM_MASK,       // Alarm latch mask
    output logic [15:0]                O_ALARM_STATUS,     // Latched alarms
    output logic [7:0]                 O_SWITCH_STATE,     // Switch and alert state
    output bmsc_pkg::bmsc_switch_t     O_DRIVER_BLOCK,     // Drivers held off
    output bmsc_pkg::bmsc_switch_t     O_TEST_ENABLE,      // Test-mode switch enables
    output logic                       O_LOCKED,           // Locked access level
    output logic                       O_FW_SWITCH_CTRL,   // 1 firmware, 0 test mode
    output logic                       O_PERMFAULT_ON,     // Permfault check on
    output logic                       O_CONFIG_EDIT,      // Config edit mode
    output logic                       O_SLEEP_ALLOWED,    // Sleep allowed
    output logic                       O_DEEP_REST,        // Deep rest requested
    output bmsc_pkg::bmsc_pulse_t      O_PULSE,            // One-cycle actions
    output logic [31:0]                O_CHARGE_RESTART    // Charge restart value
);
    import bmsc_pkg::*;

    initial begin
        if (PAIR_WINDOW_CYC < 1) $error("PAIR_WINDOW_CYC must be positive");
    end

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic         alert_s1_r;
    logic         alert_s2_r;
    bmsc_switch_t sw_s1_r;
    bmsc_switch_t sw_s2_r;

    // The alert pin and switch sense lines are outside this clock
    always_ff @(posedge I_CLK_SYS) begin
        if (I_SYS_RST) begin
            alert_s1_r <= 1'b0;
            alert_s2_r <= 1'b0;
            sw_s1_r    <= '0;
            sw_s2_r    <= '0;
        end else if (I_CE) begin
            alert_s1_r <= I_ALERT_PIN;
            alert_s2_r <= alert_s1_r;
            sw_s1_r    <= I_SWITCH_ON;
            sw_s2_r    <= sw_s1_r;
        end
    end

    // Status register, reserved bits read zero
    always_ff @(posedge I_CLK_SYS) begin
        if (I_SYS_RST) begin
            O_SWITCH_STATE <= 8'h00;
        end else if (I_CE) begin
            O_SWITCH_STATE                  <= 8'h00;
            O_SWITCH_STATE[`BMSC_ALERT_BIT] <= alert_s2_r;
            O_SWITCH_STATE[3:0]             <= sw_s2_r;
        end
    end

    // ------------------------------------------------------------
    // Alarm mask and latch
    // ------------------------------------------------------------
    always_ff @(posedge I_CLK_SYS) begin
        if (I_SYS_RST) begin
            O_ALARM_MASK <= 16'h0000;
        end else if (I_CE) begin
            if (I_DEFAULTS_LOAD) begin
                O_ALARM_MASK <= I_MASK_DEFAULT;
            end else if (I_MASK_WE) begin
                O_ALARM_MASK <= I_MASK_WDATA;
            end
        end
    end

    // A new raw event wins over a clear in the same cycle
    always_ff @(posedge I_CLK_SYS) begin
        if (I_SYS_RST) begin
            O_ALARM_STATUS <= 16'h0000;
        end else if (I_CE) begin
            O_ALARM_STATUS <= (O_ALARM_STATUS & ~I_ALARM_CLR)
                            | (I_ALARM_RAW & O_ALARM_MASK);
        end
    end

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    logic       cmd;
    logic       pair_open;
    bmsc_pair_t pair_r;
    logic       deep_second;
    logic       shut_second;
    logic       pair_start;
    logic       pair_stop;

    assign cmd         = I_CMD_VALID;
    assign deep_second = cmd && I_CMD_CODE == `BMSC_ENTER_DEEP_REST
                         && pair_r == BMSC_PAIR_DEEP && pair_open;
    assign shut_second = cmd && I_CMD_CODE == `BMSC_SHUTDOWN
                         && pair_r == BMSC_PAIR_SHUT && pair_open;
    // A first half opens the window; anything else closes it
    assign pair_start  = cmd && !deep_second && !shut_second
                         && (I_CMD_CODE == `BMSC_ENTER_DEEP_REST
                             || I_CMD_CODE == `BMSC_SHUTDOWN);
    assign pair_stop   = (cmd && !pair_start) || I_OTHER_WRITE;

    bmsc_pair_timer #(
        .WINDOW_CYC (PAIR_WINDOW_CYC)
    ) u_pair_timer (
        .I_CLK_SYS (I_CLK_SYS),
        .I_SYS_RST (I_SYS_RST),
        .i_ce      (I_CE),
        .i_start   (pair_start),
        .i_stop    (pair_stop),
        .o_open    (pair_open)
    );

    // Remember which pair the open window belongs to
    always_ff @(posedge I_CLK_SYS) begin
        if (I_SYS_RST) begin
            pair_r <= BMSC_PAIR_NONE;
        end else if (I_CE) begin
            if (pair_start) begin
                pair_r <= (I_CMD_CODE == `BMSC_SHUTDOWN) ? BMSC_PAIR_SHUT : BMSC_PAIR_DEEP;
            end else if (pair_stop) begin
                pair_r <= BMSC_PAIR_NONE;
            end
        end
    end

    // ------------------------------------------------------------
    // Access level and mode bits
    // ------------------------------------------------------------
    logic unlocked_cmd;
    logic test_cmd;
    assign unlocked_cmd = cmd && !O_LOCKED;
    assign test_cmd     = unlocked_cmd && !O_FW_SWITCH_CTRL;

    // Lock has no unlock path here; unlocking belongs to the key logic
    always_ff @(posedge I_CLK_SYS) begin
        if (I_SYS_RST) begin
            O_LOCKED <= 1'b0;
        end else if (I_CE && cmd && I_CMD_CODE == `BMSC_LOCK_ACCESS) begin
            O_LOCKED <= 1'b1;
        end
    end

    // Manufacturing toggles
    always_ff @(posedge I_CLK_SYS) begin
        if (I_SYS_RST) begin
            O_FW_SWITCH_CTRL <= 1'b1;
            O_PERMFAULT_ON   <= 1'b0;
        end else if (I_CE && unlocked_cmd) begin
            if (I_CMD_CODE == `BMSC_SWITCH_CTRL_TOGGLE) begin
                O_FW_SWITCH_CTRL <= !O_FW_SWITCH_CTRL;
            end
            if (I_CMD_CODE == `BMSC_PERMFAULT_TOGGLE) begin
                O_PERMFAULT_ON <= !O_PERMFAULT_ON;
            end
        end
    end

    // Test enables toggle only in switch test mode
    always_ff @(posedge I_CLK_SYS) begin
        if (I_SYS_RST) begin
            O_TEST_ENABLE <= '0;
        end else if (I_CE && test_cmd) begin
            unique case (I_CMD_CODE)
                `BMSC_PREDISCHARGE_TEST: begin
                    O_TEST_ENABLE.predischarge <= !O_TEST_ENABLE.predischarge;
                end
                `BMSC_PRECHARGE_TEST: begin
                    O_TEST_ENABLE.precharge <= !O_TEST_ENABLE.precharge;
                end
                `BMSC_CHARGE_TEST: begin
                    O_TEST_ENABLE.charge <= !O_TEST_ENABLE.charge;
                end
                `BMSC_DISCHARGE_TEST: begin
                    O_TEST_ENABLE.discharge <= !O_TEST_ENABLE.discharge;
                end
                default: begin
                end
            endcase
        end
    end

    // Config edit mode
    always_ff @(posedge I_CLK_SYS) begin
        if (I_SYS_RST) begin
            O_CONFIG_EDIT <= 1'b0;
        end else if (I_CE) begin
            if (unlocked_cmd && I_CMD_CODE == `BMSC_ENTER_CONFIG) begin
                O_CONFIG_EDIT <= 1'b1;
            end else if (cmd && I_CMD_CODE == `BMSC_LEAVE_CONFIG) begin
                O_CONFIG_EDIT <= 1'b0;
            end
        end
    end

    // Driver blocks accumulate until released
    always_ff @(posedge I_CLK_SYS) begin
        if (I_SYS_RST) begin
            O_DRIVER_BLOCK <= '0;
        end else if (I_CE && cmd) begin
            unique case (I_CMD_CODE)
                `BMSC_DISCHARGE_OFF: begin
                    O_DRIVER_BLOCK.discharge    <= 1'b1;
                    O_DRIVER_BLOCK.predischarge <= 1'b1;
                end
                `BMSC_CHARGE_OFF: begin
                    O_DRIVER_BLOCK.charge    <= 1'b1;
                    O_DRIVER_BLOCK.precharge <= 1'b1;
                end
                `BMSC_EVERY_OFF: begin
                    O_DRIVER_BLOCK <= '1;
                end
                `BMSC_RELEASE_BLOCKS: begin
                    O_DRIVER_BLOCK <= '0;
                end
                default: begin
                end
            endcase
        end
    end

    // Sleep allowed, default from memory then commands
    always_ff @(posedge I_CLK_SYS) begin
        if (I_SYS_RST) begin
            O_SLEEP_ALLOWED <= 1'b0;
        end else if (I_CE) begin
            if (I_DEFAULTS_LOAD) begin
                O_SLEEP_ALLOWED <= I_SLEEP_DEFAULT;
            end else if (cmd && I_CMD_CODE == `BMSC_SLEEP_ALLOW) begin
                O_SLEEP_ALLOWED <= 1'b1;
            end else if (cmd && I_CMD_CODE == `BMSC_SLEEP_FORBID) begin
                O_SLEEP_ALLOWED <= 1'b0;
            end
        end
    end

    // Deep rest state
    always_ff @(posedge I_CLK_SYS) begin
        if (I_SYS_RST) begin
            O_DEEP_REST <= 1'b0;
        end else if (I_CE) begin
            if (deep_second) begin
                O_DEEP_REST <= 1'b1;
            end else if (cmd && I_CMD_CODE == `BMSC_LEAVE_DEEP_REST) begin
                O_DEEP_REST <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // One-cycle action pulses
    // ------------------------------------------------------------
    always_ff @(posedge I_CLK_SYS) begin
        if (I_SYS_RST) begin
            O_PULSE          <= '0;
            O_CHARGE_RESTART <= 32'h0000_0000;
        end else if (I_CE) begin
            O_PULSE                 <= '0;
            O_PULSE.enter_deep_rest <= deep_second;
            O_PULSE.leave_deep_rest <= cmd && I_CMD_CODE == `BMSC_LEAVE_DEEP_REST;
            // Unlocked: one code starts; a second one skips delays
            O_PULSE.shutdown_start  <= (shut_second
                                        || (unlocked_cmd && pair_start
                                            && I_CMD_CODE == `BMSC_SHUTDOWN));
            O_PULSE.shutdown_fast   <= shut_second && !O_LOCKED;
            O_PULSE.device_reset    <= unlocked_cmd && I_CMD_CODE == `BMSC_DEVICE_RESET;
            O_PULSE.clear_accumulated_charge <= cmd && I_CMD_CODE == `BMSC_CLEAR_CHARGE;
            O_PULSE.precharge_timeout_recovery
                <= cmd && I_CMD_CODE == `BMSC_PRECHARGE_RECOVERY;
            O_PULSE.clear_boot_flags <= cmd && I_CMD_CODE == `BMSC_LEAVE_CONFIG;
            if (cmd && I_CMD_CODE == `BMSC_CLEAR_CHARGE) begin
                O_CHARGE_RESTART <= `BMSC_CHARGE_HALF;
            end
        end
    end
endmodule

// ### bmsc_host_model.sv
`timescale 1ns/1ns
// Host side of the command port
module bmsc_host_model (
    input  wire logic   i_clk,   // System clock
    output logic        o_valid, // Command strobe
    output logic [15:0] o_code,  // Command code
    output logic        o_other  // Other host write
);
    // Quiet port at time zero
    initial begin
        o_valid = 1'b0;
        o_code  = 16'hffff;
        o_other = 1'b0;
    end
    // One code per edge; calls in a row go back to back
    task automatic send(input logic [15:0] c);
        @(negedge i_clk);
        o_valid = 1'b1;
        o_code  = c;
    endtask
    // Drop the strobe; invert the code so no stale word lingers
    task automatic idle();
        @(negedge i_clk);
        o_valid = 1'b0;
        o_code  = ~o_code;
    endtask
    // A write elsewhere breaks any pending pair
    task automatic other();
        @(negedge i_clk);
        o_other = 1'b1;
        @(negedge i_clk);
        o_other = 1'b0;
    endtask
endmodule

// ### bmsc_core_assertions.sv
`timescale 1ns/1ns
// Port-level checks of the decoder
module bmsc_core_chk (
    input wire logic                   I_CLK_SYS,        // Clock
    input wire logic                   I_SYS_RST,        // Reset
    input wire logic                   I_CE,             // Enable
    input wire logic                   I_CMD_VALID,      // Strobe
    input wire logic [15:0]            I_CMD_CODE,       // Code
    input wire logic                   I_OTHER_WRITE,    // Other write
    input wire logic [15:0]            I_ALARM_RAW,      // Raw alarms
    input wire logic [15:0]            I_ALARM_CLR,      // Clears
    input wire logic                   I_ALERT_PIN,      // Alert pin
    input wire bmsc_pkg::bmsc_switch_t I_SWITCH_ON,      // Switch pins
    input wire logic [15:0]            O_ALARM_MASK,     // Mask
    input wire logic [15:0]            O_ALARM_STATUS,   // Latched
    input wire logic [7:0]             O_SWITCH_STATE,   // Status
    input wire bmsc_pkg::bmsc_switch_t O_DRIVER_BLOCK,   // Blocks
    input wire bmsc_pkg::bmsc_switch_t O_TEST_ENABLE,    // Test bits
    input wire logic                   O_LOCKED,         // Locked
    input wire logic                   O_FW_SWITCH_CTRL, // Firmware
    input wire logic                   O_CONFIG_EDIT,    // Config
    input wire logic                   O_DEEP_REST,      // Deep rest
    input wire bmsc_pkg::bmsc_pulse_t  O_PULSE,          // Pulses
    input wire logic [31:0]            O_CHARGE_RESTART  // Restart
);
    import bmsc_pkg::*;
    logic tk; // A command is taken at this edge
    assign tk = I_CE && I_CMD_VALID;
    default clocking cb @(posedge I_CLK_SYS); endclocking
    default disable iff (I_SYS_RST);
    sequence c(logic [15:0] v);
        tk && I_CMD_CODE == v;
    endsequence
    // Quiet port: nothing may fall between the halves of a pair
    sequence quiet3;
        (I_CE && !I_CMD_VALID && !I_OTHER_WRITE)[*3];
    endsequence
    // Opener just after a leave cannot close an older pair
    sequence deep_pair;
        (O_PULSE.leave_deep_rest && tk && I_CMD_CODE == 16'h000f) ##1 quiet3 ##1 c(16'h000f);
    endsequence
    alarm_latch_a: assert property (I_CE |=> O_ALARM_STATUS == (
        ($past(O_ALARM_STATUS) & ~$past(I_ALARM_CLR)) | ($past(I_ALARM_RAW) & $past(O_ALARM_MASK))))
        else $error("latched alarms wrong");
    alert_bit_a: assert property (
        I_CE [*4] |-> O_SWITCH_STATE[6] == $past(I_ALERT_PIN, 3))
        else $error("alert bit wrong");
    switch_bits_a: assert property (
        I_CE [*4] |-> O_SWITCH_STATE[3:0] == $past(I_SWITCH_ON, 3)
        && O_SWITCH_STATE[7] == 1'b0 && O_SWITCH_STATE[5:4] == 2'b00)
        else $error("switch bits wrong");
    dsg_block_a: assert property (
        c(16'h0093) |=> O_DRIVER_BLOCK.discharge && O_DRIVER_BLOCK.predischarge)
        else $error("discharge not blocked");
    release_a: assert property (c(16'h0096) |=> O_DRIVER_BLOCK == 4'h0)
        else $error("blocks not cleared");
    locked_ignore_a: assert property (
        O_LOCKED && tk && I_CMD_CODE inside {16'h0012, 16'h001c, 16'h001e, 16'h001f,
        16'h0020, 16'h0022, 16'h0024, 16'h0090} |=> !O_PULSE.device_reset
        && $stable({O_TEST_ENABLE, O_FW_SWITCH_CTRL, O_CONFIG_EDIT}))
        else $error("refused command acted");
    test_toggle_a: assert property (
        !O_LOCKED && !O_FW_SWITCH_CTRL && tk && I_CMD_CODE == 16'h001f
        |=> O_TEST_ENABLE.charge != $past(O_TEST_ENABLE.charge))
        else $error("charge test not toggled");
    charge_clear_a: assert property (
        c(16'h0082) |=> O_PULSE.clear_accumulated_charge && O_CHARGE_RESTART == 32'h0000_8000)
        else $error("charge clear missing");
    config_leave_a: assert property (
        c(16'h0092) |=> !O_CONFIG_EDIT && O_PULSE.clear_boot_flags)
        else $error("config edit not left");
    deep_enter_a: assert property (deep_pair |=> O_PULSE.enter_deep_rest && O_DEEP_REST)
        else $error("deep rest pair ignored");
    shut_fast_a: assert property (
        c(16'h0010) ##1 (tk && I_CMD_CODE == 16'h0010 && !O_LOCKED && O_PULSE.shutdown_start
        && !O_PULSE.shutdown_fast) |=> O_PULSE.shutdown_start && O_PULSE.shutdown_fast)
        else $error("fast shutdown missing");
endmodule
bind bmsc_core bmsc_core_chk u_chk (.*);

// ### bmsc_core_tb.sv
`timescale 1ns/1ns
// Self-checking bench with a behavioural model
module bmsc_core_tb;
    import bmsc_pkg::*;
    localparam int W = 20; // Short pair window for sim
    logic         clk, rst, ce, we, ld, sdef, alert, vld, oth;
    logic [15:0]  code, raw, clr, wd, mdef, o_mask, o_st, m_st, m_mask;
    logic [7:0]   o_ss, ep;
    logic [31:0]  o_rv;
    bmsc_switch_t sw, o_blk, o_te, blk, te;
    bmsc_pulse_t  o_pul;
    logic         o_lk, o_fw, o_pf, o_cfg, o_slp, o_dp, lk, fw, pf, cfg, slp, dp;
    int           cyc = 0, pend = 0, t0 = 0, err_total = 0, n_compared = 0;
    wire [21:0]   seen = {o_pul, o_blk, o_te, o_lk, o_fw, o_pf, o_cfg, o_slp, o_dp};
    wire [21:0]   want = {ep, blk, te, lk, fw, pf, cfg, slp, dp};
    bmsc_core #(.PAIR_WINDOW_CYC(W)) dut (
        .I_CLK_SYS(clk), .I_SYS_RST(rst), .I_CE(ce), .I_CMD_VALID(vld), .I_CMD_CODE(code),
        .I_OTHER_WRITE(oth), .I_ALARM_RAW(raw), .I_ALARM_CLR(clr), .I_MASK_WE(we),
        .I_MASK_WDATA(wd), .I_MASK_DEFAULT(mdef), .I_SLEEP_DEFAULT(sdef),
        .I_DEFAULTS_LOAD(ld), .I_ALERT_PIN(alert), .I_SWITCH_ON(sw), .O_ALARM_MASK(o_mask),
        .O_ALARM_STATUS(o_st), .O_SWITCH_STATE(o_ss), .O_DRIVER_BLOCK(o_blk),
        .O_TEST_ENABLE(o_te), .O_LOCKED(o_lk), .O_FW_SWITCH_CTRL(o_fw), .O_PERMFAULT_ON(o_pf),
        .O_CONFIG_EDIT(o_cfg), .O_SLEEP_ALLOWED(o_slp), .O_DEEP_REST(o_dp), .O_PULSE(o_pul),
        .O_CHARGE_RESTART(o_rv));
    bmsc_host_model h (.i_clk(clk), .o_valid(vld), .o_code(code), .o_other(oth));
    // Clock, 40 ns period
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // Edge count for the pair window in the model
    always @(posedge clk) cyc <= cyc + 1;
    // Hang guard, far beyond the run's length
    initial begin
        #400000;
        err_total++;
        results();
    end
    // Comparison against the model
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        n_compared++;
        if (s !== e) begin
            err_total++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic results();
        $display("compared %0d, mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // Any code breaks a pending pair; a finished pair leaves none
    task automatic model(input logic [15:0] c);
        logic pr;
        pr = (c == 16'h000f || c == 16'h0010) && pend == c && cyc - t0 <= W;
        pend = pr ? 0 : c;
        t0 = cyc;
        ep = 8'h00;
        case (c)
            16'h000e: begin
                dp = 1'b0;
                ep[6] = 1'b1;
            end
            16'h000f: begin
                dp = dp | pr;
                ep[7] = pr;
            end
            16'h0010: begin
                ep[5] = !lk || pr;
                ep[4] = !lk && pr;
            end
            16'h0012: ep[3] = !lk;
            16'h001c: te[3] ^= !lk && !fw;
            16'h001e: te[1] ^= !lk && !fw;
            16'h001f: te[0] ^= !lk && !fw;
            16'h0020: te[2] ^= !lk && !fw;
            16'h0022: fw ^= !lk;
            16'h0024: pf ^= !lk;
            16'h0030: lk = 1'b1;
            16'h0082: ep[2] = 1'b1;
            16'h008a: ep[1] = 1'b1;
            16'h0090: cfg |= !lk;
            16'h0092: begin
                cfg = 1'b0;
                ep[0] = 1'b1;
            end
            16'h0093: blk |= 4'hc;
            16'h0094: blk |= 4'h3;
            16'h0095: blk = 4'hf;
            16'h0096: blk = 4'h0;
            16'h0099: slp = 1'b1;
            16'h009a: slp = 1'b0;
            default: ;
        endcase
    endtask
    // Codes back to back; each result checked while it shows
    task automatic run(input logic [15:0] q[$]);
        foreach (q[i]) begin
            h.send(q[i]);
            if (i > 0) chk(seen, want);
            model(q[i]);
        end
        h.idle();
        chk(seen, want);
    endtask
    // Main sequence
    initial begin
        {we, ld, alert, raw, clr, wd, sw} = '0;
        {ce, rst} = 2'b11;
        {lk, pf, cfg, slp, dp, blk, te, ep, m_st, m_mask} = '0;
        fw = 1'b1;
        void'($urandom(57));
        mdef = 16'($urandom);
        sdef = 1'b1;
        repeat (5) @(negedge clk);
        rst = 1'b0;
        chk(seen, want);
        // Defaults from memory
        ld = 1'b1;
        @(negedge clk);
        ld = 1'b0;
        m_mask = mdef;
        slp = sdef;
        chk(o_mask, m_mask);
        // Random alarms; mask rewrites only with no raw flags
        for (int i = 0; i < 64; i++) begin
            @(negedge clk);
            chk(o_st, m_st);
            chk(o_mask, m_mask);
            we = (i % 8 == 7);
            wd = 16'($urandom);
            raw = we ? 16'h0000 : 16'($urandom);
            clr = 16'($urandom & $urandom & $urandom);
            m_st = (m_st & ~clr) | (raw & m_mask);
            if (we) m_mask = wd;
        end
        {we, raw, clr} = '0;
        @(negedge clk);
        chk(o_st, m_st);
        // Pins reach the status after the synchroniser
        repeat (8) begin
            alert = 1'($urandom);
            sw = 4'($urandom);
            repeat (4) @(negedge clk);
            chk(o_ss, {1'b0, alert, 2'b00, sw});
        end
        // Enable low freezes latching and command taking
        ce = 1'b0;
        raw = 16'hffff;
        h.send(16'h0095);
        h.idle();
        raw = 16'h0000;
        ce = 1'b1;
        chk(o_st, m_st);
        chk(seen, want);
        // Every code but lock, leave deep rest and the pair codes unlocked, one test toggle before test mode
        run('{16'h0099, 16'h009a, 16'h001c, 16'h0022, 16'h001c, 16'h001e, 16'h001f,
              16'h0020, 16'h001f, 16'h0024, 16'h0012, 16'h0082, 16'h008a, 16'h0090,
              16'h0092, 16'h0093, 16'h0096, 16'h0094, 16'h0095, 16'h0096, 16'h0055});
        chk(o_rv, 32'h0000_8000);
        // Deep rest pairs: gapped, tripled, and broken by another write
        run('{16'h000e, 16'h000f});
        repeat (2) @(negedge clk);
        run('{16'h000f, 16'h000f, 16'h000e});
        run('{16'h000f});
        h.other();
        pend = 0;
        run('{16'h000f});
        // Shutdown: fast pair, then one missing the window
        run('{16'h000e, 16'h0010, 16'h0010});
        run('{16'h0010});
        repeat (30) @(negedge clk);
        run('{16'h0010});
        // Locked: refused codes, then a locked shutdown pair
        run('{16'h0030, 16'h0012, 16'h001c, 16'h001e, 16'h001f, 16'h0020, 16'h0022,
              16'h0024, 16'h0090, 16'h0010, 16'h0010, 16'h0092, 16'h0082});
        results();
    end
endmodule
